/* File: inc/asc_sram_regs.vh */
// Timing constants for the asynchronous 4K x 4 static memory controller
// Functional notes
// [RQ1] Memory holds 4096 four-bit words
// [RQ2] Memory is static, clockless, level driven
// [RQ3] Deselected memory floats its data pins
// [RQ4] Read: select low, write enable high
// [RQ5] Simultaneous select and enable rise: no drive
// [RQ6] Host never drives data while memory reads; code drives in the one hold cycle after write end
// [RQ7] Read cycle 25 ns, address access 25 ns
// [RQ8] Old data held 3 ns after address
// [RQ9] Address valid at select fall; 15 ns access
// [RQ10] Memory floats within 10 ns after deselect
// [RQ11] Write strobes low 20 ns, address 20 ns
// [RQ12] Address held 2 ns after write end
// [RQ13] Write float 10 ns; redrive after 5 ns
// [RQ14] 12-bit address; data captured at write end
`ifndef ASC_SRAM_REGS_VH
`define ASC_SRAM_REGS_VH

`define ASC_CLK_PERIOD_NS        4
`define ASC_ADDR_W               12
`define ASC_DATA_W               4
`define ASC_READ_CYCLE_NS        25
`define ASC_ADDRESS_ACCESS_NS    25
`define ASC_SELECT_ACCESS_NS     15
`define ASC_DESELECT_FLOAT_NS    10
`define ASC_WRITE_PULSE_NS       20
`define ASC_WRITE_ADDR_HOLD_NS   2
`define ASC_WRITE_FLOAT_NS       10
`define ASC_WRITE_END_DRIVE_NS   5

// Least times round up, whole cycles, at least one
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_READ_CYC     `ASC_CEIL_CYC(`ASC_ADDRESS_ACCESS_NS)
`define ASC_WRITE_CYC    `ASC_CEIL_CYC(`ASC_WRITE_PULSE_NS)
`define ASC_WHOLD_CYC    `ASC_CEIL_CYC(`ASC_WRITE_ADDR_HOLD_NS)
`define ASC_FLOAT_CYC    `ASC_CEIL_CYC(`ASC_DESELECT_FLOAT_NS)

`endif

/* File: core/asc_sram_host.v */
// Host controller driving an asynchronous 4K x 4 static memory
`include "asc_sram_regs.vh"

module asc_sram_host #(
    parameter ADDR_W    = `ASC_ADDR_W,
    parameter DATA_W    = `ASC_DATA_W,
    parameter READ_CYC  = `ASC_READ_CYC,
    parameter WRITE_CYC = `ASC_WRITE_CYC,
    parameter WHOLD_CYC = `ASC_WHOLD_CYC,
    parameter FLOAT_CYC = `ASC_FLOAT_CYC
) (
    input  wire              clk_sys_in,
    input  wire              reset_n_in,
    input  wire              req_valid_in,
    input  wire              req_write_in,
    input  wire [ADDR_W-1:0] req_addr_in,
    input  wire [DATA_W-1:0] req_wdata_in,
    output wire              req_ready_out,
    output reg               rsp_valid_out,
    output reg  [DATA_W-1:0] rsp_rdata_out,
    output reg  [ADDR_W-1:0] mem_addr_out,
    output reg               mem_select_n_out,
    output reg               mem_write_n_out,
    input  wire [DATA_W-1:0] mem_data_in,
    output reg  [DATA_W-1:0] mem_data_out,
    output reg               mem_data_oe_out
);

    localparam [4:0] ST_IDLE  = 5'b0_0001;
    localparam [4:0] ST_READ  = 5'b0_0010;
    localparam [4:0] ST_WRITE = 5'b0_0100;
    localparam [4:0] ST_WHOLD = 5'b0_1000;
    localparam [4:0] ST_FLOAT = 5'b1_0000;

    // Counts above 255 cycles are not supported by the 8-bit counter
    localparam [7:0] READ_N  = READ_CYC[7:0];
    localparam [7:0] WRITE_N = WRITE_CYC[7:0];
    localparam [7:0] WHOLD_N = WHOLD_CYC[7:0];
    localparam [7:0] FLOAT_N = FLOAT_CYC[7:0];

    // Sequencer state and cycle counter
    reg [4:0]        state_q;
    reg [4:0]        state_d;
    reg [7:0]        count_q;
    reg [7:0]        count_d;

    // Next values of the registered outputs
    reg              rsp_valid_d;
    reg [DATA_W-1:0] rsp_rdata_d;
    reg [ADDR_W-1:0] mem_addr_d;
    reg              mem_select_n_d;
    reg              mem_write_n_d;
    reg [DATA_W-1:0] mem_data_d;
    reg              mem_data_oe_d;

    // Counter helpers
    wire [7:0]       count_inc;
    wire             read_done;
    wire             write_done;
    wire             whold_done;
    wire             float_done;

    assign count_inc  = count_q + 8'h01;
    assign read_done  = (count_q >= READ_N);
    assign write_done = (count_q >= WRITE_N);
    assign whold_done = (count_q >= WHOLD_N);
    assign float_done = (count_q >= FLOAT_N);

    assign req_ready_out = state_q[0];

    always @* begin
        state_d        = state_q;
        count_d        = count_q;
        rsp_valid_d    = 1'b0;
        rsp_rdata_d    = rsp_rdata_out;
        mem_addr_d     = mem_addr_out;
        mem_select_n_d = mem_select_n_out;
        mem_write_n_d  = mem_write_n_out;
        mem_data_d     = mem_data_out;
        mem_data_oe_d  = mem_data_oe_out;
        case (state_q)
            ST_IDLE: begin
                if (req_valid_in) begin
                    // Address is set with select, never after it
                    mem_addr_d     = req_addr_in; // RQ9 RQ14
                    mem_select_n_d = 1'b0;
                    count_d        = 8'h01;
                    if (req_write_in) begin
                        mem_write_n_d = 1'b0; // RQ11
                        mem_data_d    = req_wdata_in;
                        // Data drive starts with write enable low and ends one cycle after it rises
                        mem_data_oe_d = 1'b1; // RQ6
                        state_d       = ST_WRITE;
                    end else begin
                        mem_write_n_d = 1'b1; // RQ4
                        mem_data_oe_d = 1'b0; // RQ6
                        state_d       = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // Full address access time covers select access too
                if (read_done) begin // RQ7 RQ9
                    rsp_rdata_d    = mem_data_in;
                    rsp_valid_d    = 1'b1;
                    mem_select_n_d = 1'b1;
                    count_d        = 8'h01;
                    state_d        = ST_FLOAT;
                end else begin
                    count_d = count_inc;
                end
            end
            ST_WRITE: begin
                if (write_done) begin // RQ11
                    // Write enable ends the write; select stays low
                    mem_write_n_d = 1'b1; // RQ12 RQ14
                    count_d       = 8'h01;
                    state_d       = ST_WHOLD;
                end else begin
                    count_d = count_inc;
                end
            end
            ST_WHOLD: begin
                // Memory redrive is at least 5 ns away, so one held
                // cycle of data past write end keeps clear of it
                mem_data_oe_d = 1'b0; // RQ6 RQ13
                if (whold_done) begin // RQ12
                    mem_select_n_d = 1'b1;
                    count_d        = 8'h01;
                    state_d        = ST_FLOAT;
                end else begin
                    count_d = count_inc;
                end
            end
            ST_FLOAT: begin
                // Let a deselected memory release the bus before reuse
                if (float_done) begin // RQ10 RQ3
                    state_d = ST_IDLE;
                end else begin
                    count_d = count_inc;
                end
            end
            default: begin
                state_d        = ST_IDLE;
                count_d        = 8'h00;
                mem_select_n_d = 1'b1;
                mem_write_n_d  = 1'b1;
                mem_data_oe_d  = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            count_q <= 8'h00;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // Response registers
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {DATA_W{1'b0}};
        end else begin
            rsp_valid_out <= rsp_valid_d;
            rsp_rdata_out <= rsp_rdata_d;
        end
    end

    // Memory strobes come straight from flops, so no glitch reaches the pins
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_addr_out     <= {ADDR_W{1'b0}};
            mem_select_n_out <= 1'b1;
            mem_write_n_out  <= 1'b1;
        end else begin
            mem_addr_out     <= mem_addr_d;
            mem_select_n_out <= mem_select_n_d;
            mem_write_n_out  <= mem_write_n_d;
        end
    end

    // Host data drive
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_data_out    <= {DATA_W{1'b0}};
            mem_data_oe_out <= 1'b0;
        end else begin
            mem_data_out    <= mem_data_d;
            mem_data_oe_out <= mem_data_oe_d;
        end
    end

endmodule

/* File: test/asc_sram_asserts.sv */
// Checker on the memory-side strobes of the host controller
module asc_sram_asserts (
    input wire logic        clk_sys_in,
    input wire logic        reset_n_in,
    input wire logic        rsp_valid_out,
    input wire logic [11:0] mem_addr_out,
    input wire logic        mem_select_n_out,
    input wire logic        mem_write_n_out,
    input wire logic [3:0]  mem_data_out,
    input wire logic        mem_data_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_rd_start;
        $fell(mem_select_n_out) && mem_write_n_out;
    endsequence
    sequence s_rd_body;
        !mem_select_n_out [*7] ##1 rsp_valid_out;
    endsequence
    a_read_len: assert property (s_rd_start |-> s_rd_body) else $error("read length");
    a_write_pulse: assert property ($fell(mem_write_n_out) |-> !mem_write_n_out [*5] ##1 mem_write_n_out) else $error("write pulse");
    a_no_contend: assert property (!mem_select_n_out && mem_write_n_out && mem_data_oe_out |-> $past(!mem_write_n_out)) else $error("contention");
    a_write_hold: assert property ($rose(mem_write_n_out) |-> $stable(mem_addr_out) && !mem_select_n_out && mem_data_oe_out) else $error("write hold");
    a_resp_deselect: assert property (rsp_valid_out |-> $rose(mem_select_n_out)) else $error("response");
    a_addr_steady: assert property (!mem_select_n_out && !$fell(mem_select_n_out) |-> $stable(mem_addr_out)) else $error("address moved");
    a_we_selected: assert property (!mem_write_n_out |-> !mem_select_n_out && mem_data_oe_out) else $error("write unselected");
    a_float_gap: assert property ($rose(mem_select_n_out) |-> mem_select_n_out [*3]) else $error("float gap");
    a_wdata_stable: assert property (!mem_write_n_out && !$fell(mem_write_n_out) |-> $stable(mem_data_out)) else $error("write data");
endmodule
bind asc_sram_host asc_sram_asserts asc_sram_asserts_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .rsp_valid_out(rsp_valid_out), .mem_addr_out(mem_addr_out), .mem_select_n_out(mem_select_n_out), .mem_write_n_out(mem_write_n_out), .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));

/* File: test/asc_sram_model.sv */
// Behavioural 4K x 4 static memory with resolved data bus
module asc_sram_model (
    input  wire logic [11:0] addr_in,
    input  wire logic        select_n_in,
    input  wire logic        write_n_in,
    input  wire logic [3:0]  host_data_in,
    input  wire logic        host_oe_in,
    output wire logic [3:0]  bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] arr_q [0:4095];
    logic       drive_q = 1'b0;
    wire        read_mode = !select_n_in && write_n_in;
    wire [3:0]  rd_word;
    assign #25 rd_word = arr_q[addr_in];
    // Late enable keeps the memory off the bus in the host hold cycle
    always @(read_mode) drive_q <= #5 read_mode;
    // Undriven bus shows inverse of host data, not a stale value
    assign bus_out = host_oe_in ? host_data_in : (drive_q ? rd_word : ~host_data_in);
    always @(posedge write_n_in) if (!select_n_in) arr_q[addr_in] = bus_out;
endmodule

/* File: test/tb_top.sv */
// Self-checking bench: random writes, back-to-back read-back
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 0, reset_n_in = 0, req_valid_in = 0, req_write_in = 0;
    logic [11:0] req_addr_in = 0, adr [8];
    logic [3:0]  req_wdata_in = 0, dat [8], exp_q [$], rdata, dout;
    logic        rdy, rsp, sel_n, we_n, oe;
    logic [11:0] maddr;
    logic [3:0]  shadow [0:4095];
    wire  [3:0]  bus;
    int n_mismatch = 0, num_checks = 0;
    asc_sram_host asc_sram_host_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_ready_out(rdy), .rsp_valid_out(rsp),
        .rsp_rdata_out(rdata), .mem_addr_out(maddr), .mem_select_n_out(sel_n),
        .mem_write_n_out(we_n), .mem_data_in(bus), .mem_data_out(dout), .mem_data_oe_out(oe));
    asc_sram_model asc_sram_model_inst (.addr_in(maddr), .select_n_in(sel_n),
        .write_n_in(we_n), .host_data_in(dout), .host_oe_in(oe), .bus_out(bus));
    initial forever #2 clk_sys_in = ~clk_sys_in;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Valid stays up across back-to-back calls
    task automatic req(input logic wr, input logic [11:0] a, input logic [3:0] d);
        int t;
        @(negedge clk_sys_in);
        req_valid_in = 1; req_write_in = wr; req_addr_in = a; req_wdata_in = d;
        t = 0;
        while (rdy !== 1'b1 && t < 40) begin @(negedge clk_sys_in); t++; end
        if (t >= 40) n_mismatch++;
        if (wr) shadow[a] = d;
        else exp_q.push_back(shadow[a]);
        @(posedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) if (rsp === 1'b1) begin
        if (exp_q.size() == 0) `CHK("spurious", 1'b0, 1'b1)
        else `CHK("rdata", exp_q.pop_front(), rdata)
    end
    initial begin
        #50000 n_mismatch++;
        end_sim();
    end
    initial begin
        void'($urandom(2));
        repeat (6) @(posedge clk_sys_in);
        @(negedge clk_sys_in) reset_n_in = 1;
        for (int i = 0; i < 8; i++) begin
            adr[i] = (i == 0) ? 12'h0000 : (i == 7) ? 12'h0fff : 12'($urandom);
            dat[i] = 4'($urandom);
            req(1, adr[i], dat[i]);
        end
        for (int i = 0; i < 8; i++) req(0, adr[i], dat[i]);
        dat[0] = ~dat[0];
        req(1, adr[0], dat[0]);
        req(0, adr[0], dat[0]);
        @(negedge clk_sys_in) req_valid_in = 0;
        repeat (20) @(posedge clk_sys_in);
        `CHK("queue", 0, exp_q.size())
        end_sim();
    end
endmodule
